// [pkg/serial_rx_cfg.svh]
/*
  Constants for the receive event-flag block: register offsets, field
  positions, reset values and bit-time counts.
  Assumes byte-wide registers on a three-bit address.
*/
`ifndef SERIAL_RX_CFG_SVH
`define SERIAL_RX_CFG_SVH

// register byte offsets
`define OFS_STATUS_TWO 3'h0
`define OFS_RX_CONTROL 3'h1
`define OFS_IRQ_MASK 3'h2
`define OFS_DIV_LOW 3'h3
`define OFS_DIV_HIGH 3'h4

// serial_status_two fields
`define BIT_BREAK_FLAG 7
`define BIT_EDGE_FLAG 6
`define BIT_RX_INVERT 4
`define BIT_LONG_BREAK 1
`define BIT_RX_ACTIVE 0

// rx_control fields
`define BIT_LIN_ENABLE 0
`define BIT_NINE_BIT 1

// reset values
`define RST_IRQ_MASK 8'h00
`define RST_BIT_DIV 16'h0010

// bit-time counts
`define BREAK_BASE_BITS 4'ha
`define CHAR_BASE_BITS 4'ha

`endif

// [pkg/serial_rx_pkg.sv]
/*
  Types of the receive event-flag block.
  Assumes the constants in serial_rx_cfg.svh.
*/
`default_nettype none

package serial_rx_pkg;

  // receiver activity as seen by the active flag
  typedef enum logic {
    LINE_IDLE,
    LINE_ACTIVE
  } rx_state_t;

  // whole state of the top module
  typedef struct packed {
    rx_state_t st;
    logic brk_flag;
    logic edge_flag;
    logic invert;
    logic long_brk;
    logic lin_en;
    logic nine_bit;
    logic brk_done;
    logic [7:0] mask;
    logic [15:0] div;
    logic [7:0] rdata;
    logic irq;
  } evf_state_t;

  // state of one run-length counter
  typedef struct packed {
    logic [15:0] phase;
    logic [3:0] bits;
    logic half;
  } run_state_t;

  // state of the edge detector
  typedef struct packed {
    logic prev;
    logic fall;
  } edge_state_t;

endpackage

`default_nettype wire

// [pkg/rx_line_if.sv]
/*
  Carrier for the normalised receive line and the bit divisor.
  Assumes one clock shared by all users.
*/
`default_nettype none

interface rx_line_if;
  logic rx_norm;
  logic [15:0] div;
  modport drive (output rx_norm, output div);
  modport sense (input rx_norm, input div);
endinterface

`default_nettype wire

// [logic/rx_edge_detect.sv]
/*
  Falling-edge detector on the normalised receive line.
  Assumes the line is already synchronous and already polarity corrected.
*/
`default_nettype none

module rx_edge_detect (
  input wire logic clk,
  input wire logic rst,
  rx_line_if.sense line,
  output logic fall
);
  serial_rx_pkg::edge_state_t s_ff;
  serial_rx_pkg::edge_state_t nxt_s;

  // idle level is high, so no edge is reported straight after reset
  always_comb begin
    nxt_s = s_ff;
    nxt_s.prev = line.rx_norm;
    nxt_s.fall = s_ff.prev & ~line.rx_norm;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_ff <= '{prev: 1'b1, fall: 1'b0};
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign fall = s_ff.fall;

  a_fall_one_cycle: assert property (@(posedge clk) disable iff (rst)
    fall |=> !fall)
    else $error("edge pulse longer than one cycle");
endmodule // rx_edge_detect

`default_nettype wire

// [logic/rx_run_counter.sv]
/*
  Counts whole bit times while the normalised line holds LEVEL, and pulses
  at the middle of the first bit time.
  Assumes the divisor is at least three and stable while the line is busy.
*/
`default_nettype none

module rx_run_counter #(
  parameter logic LEVEL = 1'b0
) (
  input wire logic clk,
  input wire logic rst,
  rx_line_if.sense line,
  output logic [3:0] bits,
  output logic half
);
  serial_rx_pkg::run_state_t s_ff;
  serial_rx_pkg::run_state_t nxt_s;

  // any change of level restarts the run; bit count saturates at 15
  always_comb begin
    nxt_s = s_ff;
    nxt_s.half = 1'b0;
    if (line.rx_norm != LEVEL) begin
      nxt_s.phase = 16'h0000;
      nxt_s.bits = 4'h0;
    end else if (s_ff.phase == line.div - 16'h0001) begin
      nxt_s.phase = 16'h0000;
      if (s_ff.bits != 4'hf) begin
        nxt_s.bits = s_ff.bits + 4'h1;
      end
    end else begin
      nxt_s.phase = s_ff.phase + 16'h0001;
      nxt_s.half = (s_ff.bits == 4'h0) && (s_ff.phase == {1'b0, line.div[15:1]});
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign bits = s_ff.bits;
  assign half = s_ff.half;
endmodule // rx_run_counter

`default_nettype wire

// [logic/serial_rx_event_flags.sv]
/*
  Receive event flags of an asynchronous serial receiver: break-detect and
  receive-edge flags (write one to clear), receiver-active flag, polarity
  inversion, long-break select, interrupt mask and a byte register port.
  Assumes RXD is already synchronous to CLK and that the bus master keeps
  read and write strobes one cycle long and never together.
*/
// Design decisions made here: the address-and-strobe port and the address map.
//
// Contract
// [RULE1] break flag sets on break while enabled
// [RULE2] writing one clears break flag
// [RULE3] active receive edge sets edge flag
// [RULE4] edge falls normally, rises when inverted
// [RULE5] writing one clears edge flag
// [RULE6] status two has one read-only flag
// [RULE7] break length 10/11, plus one long; inhibit
// [RULE8] active flag: start bit sets, idle clears
// [RULE9] inversion applies to every receive use
// [RULE10] writing zero leaves a flag unchanged
`default_nettype none
`include "serial_rx_cfg.svh"

module serial_rx_event_flags (
  input wire logic CLK,
  input wire logic RST,
  input wire logic [2:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [7:0] RDATA,
  input wire logic RXD,
  output logic RX_ACTIVE,
  output logic FLAG_INHIBIT,
  output logic IRQ
);
  serial_rx_pkg::evf_state_t s_ff;
  serial_rx_pkg::evf_state_t nxt_s;

  rx_line_if line ();

  logic edge_pulse;
  logic [3:0] low_bits;
  logic [3:0] high_bits;
  logic low_half;
  logic [3:0] brk_thr;
  logic [3:0] char_len;
  logic brk_event;
  logic wr_status;
  logic wr_ctrl;
  logic wr_mask;
  logic wr_div_lo;
  logic wr_div_hi;
  logic [7:0] status_view;

  // one inversion point feeds edge, start, break and idle logic alike
  assign line.rx_norm = RXD ^ s_ff.invert; // see [RULE9]
  assign line.div = s_ff.div;

  // edge of the corrected line: falling when plain, rising when inverted
  rx_edge_detect u_edge (
    .clk(CLK),
    .rst(RST),
    .line(line),
    .fall(edge_pulse) // see [RULE4]
  );

  // run of zeros: start-bit check and break length
  rx_run_counter #(
    .LEVEL(1'b0)
  ) u_low_run (
    .clk(CLK),
    .rst(RST),
    .line(line),
    .bits(low_bits),
    .half(low_half)
  );

  // run of ones: idle-line length
  rx_run_counter #(
    .LEVEL(1'b1)
  ) u_high_run (
    .clk(CLK),
    .rst(RST),
    .line(line),
    .bits(high_bits),
    .half()
  );

  // thresholds in bit times; nine-bit adds one to both, long-break adds one to the break threshold only
  assign brk_thr = `BREAK_BASE_BITS + {3'h0, s_ff.nine_bit} + {3'h0, s_ff.long_brk}; // see [RULE7]
  assign char_len = `CHAR_BASE_BITS + {3'h0, s_ff.nine_bit};

  // a break is reported once per low run, as soon as it is long enough
  assign brk_event = (low_bits == brk_thr) && !s_ff.brk_done; // see [RULE7]

  // address decode
  assign wr_status = WR && (ADDR == `OFS_STATUS_TWO);
  assign wr_ctrl = WR && (ADDR == `OFS_RX_CONTROL);
  assign wr_mask = WR && (ADDR == `OFS_IRQ_MASK);
  assign wr_div_lo = WR && (ADDR == `OFS_DIV_LOW);
  assign wr_div_hi = WR && (ADDR == `OFS_DIV_HIGH);

  // status two as software sees it; bits 5, 3 and 2 read zero
  always_comb begin
    status_view = 8'h00;
    status_view[`BIT_BREAK_FLAG] = s_ff.brk_flag;
    status_view[`BIT_EDGE_FLAG] = s_ff.edge_flag;
    status_view[`BIT_RX_INVERT] = s_ff.invert;
    status_view[`BIT_LONG_BREAK] = s_ff.long_brk;
    status_view[`BIT_RX_ACTIVE] = (s_ff.st == serial_rx_pkg::LINE_ACTIVE); // see [RULE6]
  end

  // next state: flags, receiver activity, registers and read data
  always_comb begin
    nxt_s = s_ff;

    // set wins over a clear in the same cycle; a zero written is ignored
    nxt_s.brk_flag = (brk_event && s_ff.lin_en) // see [RULE1]
      || (s_ff.brk_flag && !(wr_status && WDATA[`BIT_BREAK_FLAG])); // see [RULE2] [RULE10]
    nxt_s.edge_flag = edge_pulse // see [RULE3]
      || (s_ff.edge_flag && !(wr_status && WDATA[`BIT_EDGE_FLAG])); // see [RULE5] [RULE10]

    // the guard re-arms only once the line has gone high again
    if (brk_event) begin
      nxt_s.brk_done = 1'b1;
    end else if (low_bits == 4'h0) begin
      nxt_s.brk_done = 1'b0;
    end

    // active flag follows the receiver, never the bus
    unique case (s_ff.st)
      serial_rx_pkg::LINE_IDLE: begin
        if (low_half) begin
          nxt_s.st = serial_rx_pkg::LINE_ACTIVE; // see [RULE8]
        end
      end
      serial_rx_pkg::LINE_ACTIVE: begin
        if (high_bits >= char_len) begin
          nxt_s.st = serial_rx_pkg::LINE_IDLE; // see [RULE8]
        end
      end
    endcase

    // writable fields of status two; the active flag has no write path
    if (wr_status) begin
      nxt_s.invert = WDATA[`BIT_RX_INVERT];
      nxt_s.long_brk = WDATA[`BIT_LONG_BREAK];
    end
    if (wr_ctrl) begin
      nxt_s.lin_en = WDATA[`BIT_LIN_ENABLE];
      nxt_s.nine_bit = WDATA[`BIT_NINE_BIT];
    end
    if (wr_mask) begin
      nxt_s.mask = WDATA & 8'hc0;
    end
    if (wr_div_lo) begin
      nxt_s.div[7:0] = WDATA;
    end
    if (wr_div_hi) begin
      nxt_s.div[15:8] = WDATA;
    end

    // read data stand for one cycle only; unmapped offsets read zero
    nxt_s.rdata = 8'h00;
    if (RD) begin
      unique case (ADDR)
        `OFS_STATUS_TWO: nxt_s.rdata = status_view;
        `OFS_RX_CONTROL: nxt_s.rdata = {6'h00, s_ff.nine_bit, s_ff.lin_en};
        `OFS_IRQ_MASK: nxt_s.rdata = s_ff.mask;
        `OFS_DIV_LOW: nxt_s.rdata = s_ff.div[7:0];
        `OFS_DIV_HIGH: nxt_s.rdata = s_ff.div[15:8];
        default: nxt_s.rdata = 8'h00;
      endcase
    end

    // interrupt from the next flag values, so it tracks them exactly
    nxt_s.irq = |({nxt_s.brk_flag, nxt_s.edge_flag, 6'h00} & nxt_s.mask);
  end

  // state register
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      s_ff <= '{
        st: serial_rx_pkg::LINE_IDLE,
        brk_flag: 1'b0,
        edge_flag: 1'b0,
        invert: 1'b0,
        long_brk: 1'b0,
        lin_en: 1'b0,
        nine_bit: 1'b0,
        brk_done: 1'b0,
        mask: `RST_IRQ_MASK,
        div: `RST_BIT_DIV,
        rdata: 8'h00,
        irq: 1'b0
      };
    end else begin
      s_ff <= nxt_s;
    end
  end

  // outputs, all from flip-flops
  assign RDATA = s_ff.rdata;
  assign RX_ACTIVE = (s_ff.st == serial_rx_pkg::LINE_ACTIVE);
  assign FLAG_INHIBIT = s_ff.long_brk; // see [RULE7]
  assign IRQ = s_ff.irq;

  // break flag rises only when detection was enabled
  a_break_needs_enable: assert property (@(posedge CLK) disable iff (RST) // see [RULE1]
    $rose(s_ff.brk_flag) |-> $past(s_ff.lin_en) && $past(brk_event))
    else $error("break flag set without enabled break detection");

  // a one written clears the break flag when no break arrives
  a_break_w1c: assert property (@(posedge CLK) disable iff (RST) // see [RULE2]
    (wr_status && WDATA[7] && !(brk_event && s_ff.lin_en)) |=> !s_ff.brk_flag)
    else $error("break flag not cleared by write of one");

  // every active edge sets the edge flag
  a_edge_sets_flag: assert property (@(posedge CLK) disable iff (RST) // see [RULE3]
    edge_pulse |=> s_ff.edge_flag)
    else $error("edge flag missed an active edge");

  // the edge seen matches the polarity setting
  a_edge_polarity: assert property (@(posedge CLK) disable iff (RST) // see [RULE4]
    (edge_pulse && $stable(s_ff.invert)) |->
      ($past(RXD, 1) == s_ff.invert) && ($past(RXD, 2) != s_ff.invert))
    else $error("edge reported on the wrong polarity");

  // a one written clears the edge flag when no edge arrives
  a_edge_w1c: assert property (@(posedge CLK) disable iff (RST) // see [RULE5]
    (wr_status && WDATA[6] && !edge_pulse) |=> !s_ff.edge_flag)
    else $error("edge flag not cleared by write of one");

  // writes never move the active flag
  a_active_read_only: assert property (@(posedge CLK) disable iff (RST) // see [RULE6]
    (wr_status && !low_half && !(high_bits >= char_len)) |=> $stable(RX_ACTIVE))
    else $error("active flag changed by a register write");

  // a break is taken exactly at its threshold length
  a_break_length: assert property (@(posedge CLK) disable iff (RST) // see [RULE7]
    $rose(s_ff.brk_done) |-> $past(low_bits) == (4'ha + {3'h0, $past(s_ff.nine_bit)}
      + {3'h0, $past(s_ff.long_brk)}))
    else $error("break taken at the wrong length");

  // a valid start bit raises the active flag
  a_start_sets_active: assert property (@(posedge CLK) disable iff (RST) // see [RULE8]
    (low_half && !RX_ACTIVE) |=> RX_ACTIVE)
    else $error("start bit did not set the active flag");

  // an idle character time drops the active flag
  a_idle_clears_active: assert property (@(posedge CLK) disable iff (RST) // see [RULE8]
    (RX_ACTIVE && high_bits >= char_len) |=> !RX_ACTIVE)
    else $error("idle line did not clear the active flag");

  // inverted line counts highs as lows for break purposes
  a_invert_break: assert property (@(posedge CLK) disable iff (RST) // see [RULE9]
    (low_bits != 4'h0) |-> $past(RXD) == $past(s_ff.invert))
    else $error("low run counted on a line that was high");

  // a zero written keeps a set break flag
  a_zero_keeps_flag: assert property (@(posedge CLK) disable iff (RST) // see [RULE10]
    (wr_status && !WDATA[7] && s_ff.brk_flag) |=> s_ff.brk_flag)
    else $error("break flag lost on a write of zero");

  // interrupt equals the unmasked flags in every cycle, with no lag behind them
  a_irq_tracks: assert property (@(posedge CLK) disable iff (RST)
    IRQ == |({s_ff.brk_flag, s_ff.edge_flag} & s_ff.mask[7:6]))
    else $error("interrupt output disagrees with flags and mask");

  // an edge flag only rises from a seen edge, so a clear sticks until the next one
  a_edge_needs_cause: assert property (@(posedge CLK) disable iff (RST) // see [RULE5]
    $rose(s_ff.edge_flag) |-> $past(edge_pulse))
    else $error("edge flag set without an active edge");

  // a zero written keeps a set edge flag
  a_zero_keeps_edge: assert property (@(posedge CLK) disable iff (RST) // see [RULE10]
    (wr_status && !WDATA[`BIT_EDGE_FLAG] && s_ff.edge_flag) |=> s_ff.edge_flag)
    else $error("edge flag lost on a write of zero");

  // long-break select written to status two drives the inhibit output
  a_inhibit_follows: assert property (@(posedge CLK) disable iff (RST) // see [RULE7]
    wr_status |=> FLAG_INHIBIT == $past(WDATA[`BIT_LONG_BREAK]))
    else $error("inhibit output does not follow the long-break bit");

  // polarity bit written to status two takes effect on the next cycle
  a_invert_write: assert property (@(posedge CLK) disable iff (RST) // see [RULE9]
    wr_status |=> s_ff.invert == $past(WDATA[`BIT_RX_INVERT]))
    else $error("polarity bit not taken from the write");

  // without a start bit an idle receiver stays idle
  a_idle_holds: assert property (@(posedge CLK) disable iff (RST) // see [RULE8]
    (!RX_ACTIVE && !low_half) |=> !RX_ACTIVE)
    else $error("active flag set without a start bit");

  // read data stand only in the cycle after a read strobe
  a_rdata_idle: assert property (@(posedge CLK) disable iff (RST)
    !$past(RD) |-> RDATA == 8'h00)
    else $error("read data present without a read strobe");

  // unmapped offsets read zero
  a_unmapped_zero: assert property (@(posedge CLK) disable iff (RST)
    (RD && ADDR > `OFS_DIV_HIGH) |=> RDATA == 8'h00)
    else $error("unmapped offset returned nonzero data");
endmodule // serial_rx_event_flags

`default_nettype wire

// [testbench/remote_node.sv]
/*
  Model of the remote serial node that drives the receive pin.
  Assumes one shared clock; the pin rests at the stop level between runs.
*/
`default_nettype none

module remote_node (
  input wire logic clk,
  input wire logic rst,
  input wire logic invert,
  input wire logic go,
  input wire logic [15:0] low_len,
  output logic rxd
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] left_ff;

  // low run counter; a new go restarts it at once
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      left_ff <= 16'h0000;
    end else if (go) begin
      left_ff <= low_len;
    end else if (left_ff != 16'h0000) begin
      left_ff <= left_ff - 16'h0001;
    end
  end

  // pin level follows the far node's own polarity, so the receiver must invert it back
  assign rxd = (left_ff == 16'h0000) ^ invert;
endmodule // remote_node

`default_nettype wire

// [testbench/testbench.sv]
/*
  Self-checking bench for the receive event-flag block.
  Assumes the remote_node model and the block's register map.
*/
`default_nettype none

module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {logic [2:0] a; logic [7:0] w; logic [7:0] r;} row_t;
  logic CLK, RST, WR, RD, RXD, RX_ACTIVE, FLAG_INHIBIT, IRQ, node_inv, go;
  logic [2:0] ADDR;
  logic [7:0] WDATA, RDATA, got;
  logic [15:0] low_len;
  int errors, n_compared, cycles, i, thr;
  logic inv, l, n, lin;
  row_t rows [10] = '{'{3'h3, 8'h04, 8'h04}, '{3'h4, 8'h00, 8'h00}, '{3'h0, 8'h02, 8'h02},
    '{3'h0, 8'h00, 8'h00}, '{3'h2, 8'hff, 8'hc0}, '{3'h2, 8'h00, 8'h00},
    '{3'h5, 8'hff, 8'h00}, '{3'h7, 8'ha5, 8'h00}, '{3'h0, 8'h2d, 8'h00},
    '{3'h1, 8'h01, 8'h01}};

  serial_rx_event_flags DUT (.CLK(CLK), .RST(RST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR),
    .RD(RD), .RDATA(RDATA), .RXD(RXD), .RX_ACTIVE(RX_ACTIVE), .FLAG_INHIBIT(FLAG_INHIBIT),
    .IRQ(IRQ));
  remote_node node (.clk(CLK), .rst(RST), .invert(node_inv), .go(go), .low_len(low_len),
    .rxd(RXD));

  // 40 MHz clock
  initial begin
    CLK = 1'b0;
    forever #12.5 CLK = ~CLK;
  end

  // hang guard, well above the under two thousand cycles the run needs
  always @(posedge CLK) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      summarize();
    end
  end

  task automatic summarize();
    if (errors == 0 && n_compared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic cyc(input int k);
    repeat (k) @(posedge CLK);
  endtask

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge CLK);
    ADDR <= a;
    WDATA <= d;
    WR <= 1'b1;
    @(posedge CLK);
    WR <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe, so sample just past that edge
  task automatic chk_rd(input logic [2:0] a, input logic [7:0] e);
    @(posedge CLK);
    ADDR <= a;
    RD <= 1'b1;
    @(posedge CLK);
    RD <= 1'b0;
    #1 got = RDATA;
    chk("rdata", got, e);
  endtask

  task automatic pulse(input logic [15:0] len);
    @(posedge CLK);
    low_len <= len;
    go <= 1'b1;
    @(posedge CLK);
    go <= 1'b0;
  endtask

  initial begin
    {WR, RD, go, node_inv, ADDR, WDATA, low_len} = '0;
    RST = 1'b1;
    repeat (3) @(posedge CLK);
    RST <= 1'b0;
    foreach (rows[k]) begin
      wr(rows[k].a, rows[k].w);
      chk_rd(rows[k].a, rows[k].r);
    end
    // reset again mid-run and look at the defaults
    @(posedge CLK);
    RST <= 1'b1;
    cyc(3);
    chk("outs", {5'h00, IRQ, RX_ACTIVE, FLAG_INHIBIT}, 8'h00);
    RST <= 1'b0;
    chk_rd(3'h0, 8'h00);
    chk_rd(3'h3, 8'h10);
    wr(3'h3, 8'h04);
    // both polarities; changing polarity may raise a spurious edge, so clear after idle
    for (i = 0; i < 2; i++) begin
      inv = i[0];
      node_inv <= inv;
      wr(3'h0, {3'b000, inv, 4'h0});
      cyc(60);
      wr(3'h0, {2'b11, 1'b0, inv, 4'h0});
      chk_rd(3'h0, {3'b000, inv, 4'h0});
      pulse(16'h0014);
      cyc(6);
      chk_rd(3'h0, {3'b010, inv, 4'h1});
      wr(3'h0, {3'b010, inv, 4'h0});
      cyc(60);
      chk_rd(3'h0, {3'b000, inv, 4'h0});
    end
    node_inv <= 1'b0;
    wr(3'h0, 8'h00);
    cyc(60);
    wr(3'h0, 8'hc0);
    // interrupt raised by an unmasked edge flag, then cleared
    wr(3'h2, 8'h40);
    pulse(16'h0002);
    cyc(50);
    chk("irq", {7'h00, IRQ}, 8'h01);
    wr(3'h0, 8'h00);
    chk_rd(3'h0, 8'h40);
    wr(3'h0, 8'h40);
    // the clear lands at the edge the write task returns on; look one cycle on
    cyc(1);
    chk("irq", {7'h00, IRQ}, 8'h00);
    wr(3'h2, 8'h80);
    // break lengths for every mode, last row with detection disabled
    for (i = 0; i < 5; i++) begin
      lin = (i != 4);
      l = i[0];
      n = i[1];
      thr = (10 + n + l) * 4;
      wr(3'h1, {6'h00, n, lin});
      wr(3'h0, {2'b11, 4'h0, l, 1'b0});
      // the write is taken at the edge the task returns on; the output moves after it
      cyc(1);
      chk("inhibit", {7'h00, FLAG_INHIBIT}, {7'h00, l});
      pulse(16'(thr - 3));
      cyc(thr + 60);
      chk_rd(3'h0, {2'b01, 4'h0, l, 1'b0});
      wr(3'h0, {2'b11, 4'h0, l, 1'b0});
      pulse(16'(thr + 12));
      cyc(thr + 4);
      chk_rd(3'h0, {lin, 5'b10000, l, 1'b1});
      chk("irq", {7'h00, IRQ}, {7'h00, lin});
      chk("active", {7'h00, RX_ACTIVE}, 8'h01);
      wr(3'h0, {6'h00, l, 1'b0});
      chk_rd(3'h0, {lin, 5'b10000, l, 1'b1});
      cyc(70);
      chk_rd(3'h0, {lin, 5'b10000, l, 1'b0});
      wr(3'h0, {2'b10, 4'h0, l, 1'b0});
      chk_rd(3'h0, {2'b01, 4'h0, l, 1'b0});
    end
    summarize();
  end
endmodule // testbench

`default_nettype wire
